/* fcfd_decoder.sv */
// Module: command flag decoder with spin-up and settle timing
`timescale 1ns/1ps

module fcfd_decoder #(
  parameter int STEP_6_CYC = fcfd_pkg::STEP_6_MS * fcfd_pkg::CYC_PER_MS,
  parameter int STEP_12_CYC = fcfd_pkg::STEP_12_MS * fcfd_pkg::CYC_PER_MS,
  parameter int STEP_20_CYC = fcfd_pkg::STEP_20_MS * fcfd_pkg::CYC_PER_MS,
  parameter int STEP_30_CYC = fcfd_pkg::STEP_30_MS * fcfd_pkg::CYC_PER_MS,
  parameter int STEP_2_CYC = fcfd_pkg::STEP_2_MS * fcfd_pkg::CYC_PER_MS,
  parameter int STEP_3_CYC = fcfd_pkg::STEP_3_MS * fcfd_pkg::CYC_PER_MS,
  parameter int SETTLE_STD_CYC = fcfd_pkg::SETTLE_STD_MS * fcfd_pkg::CYC_PER_MS,
  parameter int SETTLE_FAST_CYC = fcfd_pkg::SETTLE_FAST_MS * fcfd_pkg::CYC_PER_MS
) (
  input wire logic clock, // System clock, 250 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [3:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic drive_ready, // Drive ready pin
  input wire logic index_pulse, // Drive index pin
  input wire logic cmd_done, // Sequencer finished command
  output logic [23:0] step_period_cyc, // Step interval in cycles
  output fcfd_pkg::fcfd_opts_t opts, // Decoded options
  output logic cmd_start, // Pulse: sequencer may execute
  output logic cmd_abort, // Pulse: terminate current command
  output logic spindle_motor_on, // Spindle motor drive
  output logic irq // Interrupt, level
);

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  logic [1:0] ready_sync_reg;
  logic [1:0] index_sync_reg;
  logic ready_d_reg;
  logic index_d_reg;

  // Two flops on each pin, then one more for edge detect
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ready_sync_reg <= 2'h0;
      index_sync_reg <= 2'h0;
      ready_d_reg <= 1'b0;
      index_d_reg <= 1'b0;
    end else begin
      ready_sync_reg <= {ready_sync_reg[0], drive_ready};
      index_sync_reg <= {index_sync_reg[0], index_pulse};
      ready_d_reg <= ready_sync_reg[1];
      index_d_reg <= index_sync_reg[1];
    end
  end

  logic [1:0] prime_cnt_reg;
  logic edge_ok;

  // Edge detect stays off until every stage holds a real pin sample
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prime_cnt_reg <= 2'h0;
    end else if (prime_cnt_reg != 2'h3) begin
      prime_cnt_reg <= prime_cnt_reg + 2'h1;
    end
  end

  assign edge_ok = (prime_cnt_reg == 2'h3); // No false edge after reset

  logic ready_rise;
  logic ready_fall;
  logic index_rise;
  assign ready_rise = edge_ok & ready_sync_reg[1] & ~ready_d_reg;
  assign ready_fall = edge_ok & ~ready_sync_reg[1] & ready_d_reg;
  assign index_rise = edge_ok & index_sync_reg[1] & ~index_d_reg;

  // -------------------------------------------------------------
  // Variant selection register
  // -------------------------------------------------------------
  logic [7:0] variant_reg;
  fcfd_pkg::fcfd_variant_t variant;
  logic side_var;
  logic fast_var;
  assign variant = fcfd_pkg::fcfd_variant_t'(variant_reg[1:0]);
  assign side_var = (variant == fcfd_pkg::FCFD_SIDE_CMP);
  assign fast_var = (variant == fcfd_pkg::FCFD_FAST_MOTOR);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      variant_reg <= fcfd_pkg::VARIANT_RST;
    end else if (wr && addr == fcfd_pkg::ADDR_VARIANT) begin
      variant_reg <= {6'h00, wdata[1:0]};
    end
  end

  // -------------------------------------------------------------
  // Command classification
  // -------------------------------------------------------------
  logic cmd_wr;
  logic force_int;
  fcfd_pkg::fcfd_class_t cls;
  assign cmd_wr = wr && (addr == fcfd_pkg::ADDR_CMD);
  assign force_int = (wdata[7:4] == 4'hD);

  // Opcode high bits give the command type
  always_comb begin
    case (wdata[7:5])
      3'h0, 3'h1, 3'h2, 3'h3: cls = fcfd_pkg::FCFD_CLS_STEP;
      3'h4: cls = fcfd_pkg::FCFD_CLS_READ;
      3'h5: cls = fcfd_pkg::FCFD_CLS_WRITE;
      3'h6: cls = force_int ? fcfd_pkg::FCFD_CLS_NONE : fcfd_pkg::FCFD_CLS_TRACK;
      3'h7: cls = wdata[4] ? fcfd_pkg::FCFD_CLS_TRACK_WR : fcfd_pkg::FCFD_CLS_TRACK;
      default: cls = fcfd_pkg::FCFD_CLS_NONE;
    endcase
  end

  // -------------------------------------------------------------
  // Option decode
  // -------------------------------------------------------------
  fcfd_pkg::fcfd_opts_t opts_next;
  logic is_step;
  logic is_sect;
  logic is_trk;
  logic is_wr;
  assign is_step = (cls == fcfd_pkg::FCFD_CLS_STEP);
  assign is_sect = (cls == fcfd_pkg::FCFD_CLS_READ) || (cls == fcfd_pkg::FCFD_CLS_WRITE);
  assign is_trk = (cls == fcfd_pkg::FCFD_CLS_TRACK) || (cls == fcfd_pkg::FCFD_CLS_TRACK_WR);
  assign is_wr = (cls == fcfd_pkg::FCFD_CLS_WRITE) || (cls == fcfd_pkg::FCFD_CLS_TRACK_WR);

  // Fields not meaningful for the command or variant decode to zero
  always_comb begin
    opts_next = '0;
    if (is_step) begin
      opts_next.step_period_code = wdata[1:0];
      opts_next.track_update = wdata[fcfd_pkg::BIT_UPDATE];
      opts_next.verify = wdata[fcfd_pkg::BIT_VERIFY];
    end
    if (is_sect) begin
      opts_next.multi_sector = wdata[fcfd_pkg::BIT_MULTI];
    end
    if (!side_var) begin
      opts_next.spinup_en = ~wdata[fcfd_pkg::BIT_MOTOR];
    end
    if (side_var && is_sect) begin
      opts_next.side_expect = wdata[fcfd_pkg::BIT_SIDE];
      opts_next.side_cmp_en = wdata[fcfd_pkg::BIT_CMP];
    end
    if (is_sect || is_trk) begin
      opts_next.settle_en = wdata[fcfd_pkg::BIT_SETTLE];
    end
    if (!side_var && is_wr) begin
      opts_next.precomp_en = ~wdata[fcfd_pkg::BIT_PRECOMP];
    end
    if (cls == fcfd_pkg::FCFD_CLS_WRITE) begin
      opts_next.deleted_mark_select = wdata[fcfd_pkg::BIT_MARK];
    end
  end

  // Track commands on the side variant leave bits 3 and 1 undecoded
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      opts <= '0;
    end else if (cmd_wr && cls != fcfd_pkg::FCFD_CLS_NONE) begin
      opts <= opts_next;
    end
  end

  // Step period lookup from latched code
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      step_period_cyc <= 24'h000000;
    end else begin
      case (opts.step_period_code)
        2'h0: step_period_cyc <= 24'(STEP_6_CYC);
        2'h1: step_period_cyc <= 24'(STEP_12_CYC);
        2'h2: step_period_cyc <= fast_var ? 24'(STEP_2_CYC) : 24'(STEP_20_CYC);
        2'h3: step_period_cyc <= fast_var ? 24'(STEP_3_CYC) : 24'(STEP_30_CYC);
        default: step_period_cyc <= 24'(STEP_6_CYC);
      endcase
    end
  end

  // -------------------------------------------------------------
  // Spin-up and settle sequencer
  // -------------------------------------------------------------
  fcfd_pkg::fcfd_state_t state_reg;
  logic [23:0] wait_reg;
  logic [2:0] rev_reg;
  logic new_cmd;
  logic want_spin;
  logic want_settle;
  assign new_cmd = cmd_wr && cls != fcfd_pkg::FCFD_CLS_NONE;
  assign want_spin = opts_next.spinup_en && !spindle_motor_on;
  assign want_settle = opts_next.settle_en;

  // Motor start waits index revolutions, settle waits a timed delay
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= fcfd_pkg::FCFD_IDLE;
      wait_reg <= 24'h000000;
      rev_reg <= 3'h0;
      cmd_start <= 1'b0;
      spindle_motor_on <= 1'b0;
    end else begin
      cmd_start <= 1'b0;
      if (cmd_wr && force_int) begin
        state_reg <= fcfd_pkg::FCFD_IDLE;
      end else begin
        case (state_reg)
          fcfd_pkg::FCFD_IDLE: begin
            if (new_cmd) begin
              rev_reg <= 3'h0;
              wait_reg <= fast_var ? 24'(SETTLE_FAST_CYC) : 24'(SETTLE_STD_CYC);
              if (want_spin) begin
                spindle_motor_on <= 1'b1;
                state_reg <= fcfd_pkg::FCFD_SPINUP;
              end else if (want_settle) begin
                state_reg <= fcfd_pkg::FCFD_SETTLE;
              end else begin
                cmd_start <= 1'b1;
                state_reg <= fcfd_pkg::FCFD_RUN;
              end
            end
          end
          fcfd_pkg::FCFD_SPINUP: begin
            if (index_rise) begin
              rev_reg <= rev_reg + 3'h1;
              if (rev_reg == 3'(fcfd_pkg::SPINUP_REVS - 1)) begin
                if (opts.settle_en) begin
                  state_reg <= fcfd_pkg::FCFD_SETTLE;
                end else begin
                  cmd_start <= 1'b1;
                  state_reg <= fcfd_pkg::FCFD_RUN;
                end
              end
            end
          end
          fcfd_pkg::FCFD_SETTLE: begin
            if (wait_reg <= 24'h000001) begin
              cmd_start <= 1'b1;
              state_reg <= fcfd_pkg::FCFD_RUN;
            end else begin
              wait_reg <= wait_reg - 24'h000001;
            end
          end
          fcfd_pkg::FCFD_RUN: begin
            if (cmd_done) begin
              state_reg <= fcfd_pkg::FCFD_IDLE;
            end
          end
          default: state_reg <= fcfd_pkg::FCFD_IDLE;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // Force interrupt conditions
  // -------------------------------------------------------------
  fcfd_pkg::fcfd_cond_t cond_reg;
  logic cond_none;
  assign cond_none = (wdata[3:0] == 4'h0);

  // Conditions latched by force-interrupt; abort pulse on every such command
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cond_reg <= '0;
      cmd_abort <= 1'b0;
    end else begin
      cmd_abort <= cmd_wr && force_int;
      if (cmd_wr && force_int) begin
        cond_reg <= fcfd_pkg::fcfd_cond_t'(wdata[3:0]);
      end
    end
  end

  // -------------------------------------------------------------
  // Interrupt status and mask
  // -------------------------------------------------------------
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] irq_set;

  // bit0 not-ready->ready, bit1 ready->not-ready, bit2 index, bit3 immediate, bit4 done
  always_comb begin
    irq_set = 8'h00;
    irq_set[0] = side_var && cond_reg.cond_not_ready_to_ready && ready_rise;
    irq_set[1] = side_var && cond_reg.cond_ready_to_not_ready && ready_fall;
    irq_set[2] = cond_reg.cond_index_pulse && index_rise;
    irq_set[3] = cmd_wr && force_int && wdata[3];
    irq_set[4] = cmd_done && !(cmd_wr && force_int && cond_none);
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_stat_reg <= 8'h00;
    end else if (wr && addr == fcfd_pkg::ADDR_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~wdata) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  // Mask register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_mask_reg <= fcfd_pkg::IRQ_MASK_RST;
    end else if (wr && addr == fcfd_pkg::ADDR_IRQ_MASK) begin
      irq_mask_reg <= wdata;
    end
  end

  // Interrupt output from a flop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // -------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------
  logic [7:0] last_cmd_reg;

  // Last accepted command word
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      last_cmd_reg <= 8'h00;
    end else if (cmd_wr) begin
      last_cmd_reg <= wdata;
    end
  end

  // Read mux, unmapped reads zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        fcfd_pkg::ADDR_CMD: rdata <= last_cmd_reg;
        fcfd_pkg::ADDR_OPT: rdata <= {opts.track_update | opts.multi_sector, opts.spinup_en,
                                      opts.settle_en | opts.verify, opts.side_cmp_en | opts.precomp_en,
                                      opts.side_expect, opts.deleted_mark_select, opts.step_period_code};
        fcfd_pkg::ADDR_STAT: rdata <= {2'h0, ready_sync_reg[1], spindle_motor_on, cond_reg.cond_index_pulse,
                                       3'(state_reg)};
        fcfd_pkg::ADDR_IRQ_STAT: rdata <= irq_stat_reg;
        fcfd_pkg::ADDR_IRQ_MASK: rdata <= irq_mask_reg;
        fcfd_pkg::ADDR_VARIANT: rdata <= variant_reg;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

/* fcfd_pkg.sv */
// Package: constants and types for the command flag decoder
package fcfd_pkg;

  // ---------------------------------------------------------------
  // Clock and times
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int STEP_6_MS = 6;
  localparam int STEP_12_MS = 12;
  localparam int STEP_20_MS = 20;
  localparam int STEP_30_MS = 30;
  localparam int STEP_2_MS = 2;
  localparam int STEP_3_MS = 3;
  localparam int SETTLE_STD_MS = 30;
  localparam int SETTLE_FAST_MS = 15;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int SPINUP_REVS = 6;

  // ---------------------------------------------------------------
  // Register offsets and field positions
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_OPT = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
  localparam logic [3:0] ADDR_VARIANT = 4'h5;
  localparam int BIT_UPDATE = 4;
  localparam int BIT_MULTI = 4;
  localparam int BIT_MOTOR = 3;
  localparam int BIT_SIDE = 3;
  localparam int BIT_VERIFY = 2;
  localparam int BIT_SETTLE = 2;
  localparam int BIT_CMP = 1;
  localparam int BIT_PRECOMP = 1;
  localparam int BIT_MARK = 0;
  localparam logic [7:0] VARIANT_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FCFD_STD_MOTOR = 2'b00,
    FCFD_FAST_MOTOR = 2'b01,
    FCFD_SIDE_CMP = 2'b10
  } fcfd_variant_t;

  typedef enum logic [2:0] {
    FCFD_CLS_NONE = 3'b000,
    FCFD_CLS_STEP = 3'b001,
    FCFD_CLS_READ = 3'b010,
    FCFD_CLS_WRITE = 3'b011,
    FCFD_CLS_TRACK = 3'b100,
    FCFD_CLS_TRACK_WR = 3'b101
  } fcfd_class_t;

  typedef enum logic [1:0] {
    FCFD_IDLE = 2'b00,
    FCFD_SPINUP = 2'b01,
    FCFD_SETTLE = 2'b10,
    FCFD_RUN = 2'b11
  } fcfd_state_t;

  // Decoded options passed to the sequencer
  typedef struct packed {
    logic [1:0] step_period_code;
    logic track_update;
    logic verify;
    logic multi_sector;
    logic spinup_en;
    logic side_expect;
    logic side_cmp_en;
    logic settle_en;
    logic precomp_en;
    logic deleted_mark_select;
  } fcfd_opts_t;

  // Interrupt condition bits of the force-interrupt command
  typedef struct packed {
    logic cond_immediate;
    logic cond_index_pulse;
    logic cond_ready_to_not_ready;
    logic cond_not_ready_to_ready;
  } fcfd_cond_t;

endpackage

/* fcfd_drive_model.sv */
// Drive and sequencer model: index pulses, ready pin and command completion
`timescale 1ns/1ps
module fcfd_drive_model #(
  parameter int IDX_PER = 40
) (
  input wire logic clock, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic ready_req, // Bench setting of drive ready
  input wire logic cmd_start, // Go pulse from decoder
  output logic drive_ready, // Drive ready pin
  output logic index_pulse, // Index pin
  output logic cmd_done // Command finished pulse
);
  int idx_cnt;
  int run_cnt;

  // Spindle: index four cycles wide once a revolution, ready follows the bench
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idx_cnt <= 0;
      index_pulse <= 1'b0;
      drive_ready <= 1'b1;
    end else begin
      idx_cnt <= (idx_cnt == IDX_PER - 1) ? 0 : idx_cnt + 1;
      index_pulse <= (idx_cnt < 4);
      drive_ready <= ready_req;
    end
  end

  // Sequencer: finishes each started command a few cycles later
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_cnt <= 0;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= (run_cnt == 1);
      if (cmd_start) begin
        run_cnt <= 5;
      end else if (run_cnt != 0) begin
        run_cnt <= run_cnt - 1;
      end
    end
  end
endmodule

/* fcfd_assertions.sv */
// Checker: concurrent properties on the decoder ports
`timescale 1ns/1ps
module fcfd_checker #(
  parameter int STEP_12_CYC = 120,
  parameter int STEP_30_CYC = 300,
  parameter int STEP_3_CYC = 30
) (
  input wire logic clock, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic [3:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic [23:0] step_period_cyc, // Step interval
  input wire fcfd_pkg::fcfd_opts_t opts, // Decoded options
  input wire logic cmd_start, // Go pulse
  input wire logic cmd_abort, // Abort pulse
  input wire logic spindle_motor_on // Motor drive
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Force-interrupt write and a freshly latched option set
  sequence force_wr_s;
    wr && addr == fcfd_pkg::ADDR_CMD && wdata[7:4] == 4'hD;
  endsequence
  sequence new_opts_s;
    $changed(opts) ##1 $stable(opts);
  endsequence

  abort_pulse_a: assert property (force_wr_s |=> cmd_abort) else $error("abort pulse missing");
  abort_cause_a: assert property (cmd_abort |-> $past(wr && addr == 4'h0 && wdata[7:4] == 4'hD))
    else $error("abort without force write");
  code_one_a: assert property (new_opts_s |-> opts.step_period_code != 2'b01 || step_period_cyc == STEP_12_CYC)
    else $error("step code one period wrong");
  code_three_a: assert property (new_opts_s |-> opts.step_period_code != 2'b11 ||
    step_period_cyc == STEP_30_CYC || step_period_cyc == STEP_3_CYC) else $error("step code three period wrong");
  settle_wait_a: assert property ($rose(opts.settle_en) |-> !cmd_start [*8]) else $error("start during settle");
  spinup_wait_a: assert property ($rose(spindle_motor_on) |-> !cmd_start [*8]) else $error("start during spin-up");
  flag_excl_a: assert property (opts.track_update |-> !opts.multi_sector && !opts.settle_en)
    else $error("step flags leak into sector fields");
  side_excl_a: assert property (opts.side_cmp_en || opts.side_expect |-> !opts.spinup_en && !opts.precomp_en)
    else $error("side flags mixed with motor flags");
endmodule

bind fcfd_decoder fcfd_checker #(.STEP_12_CYC(STEP_12_CYC), .STEP_30_CYC(STEP_30_CYC), .STEP_3_CYC(STEP_3_CYC)) chk_u (
  .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .step_period_cyc(step_period_cyc),
  .opts(opts), .cmd_start(cmd_start), .cmd_abort(cmd_abort), .spindle_motor_on(spindle_motor_on));

/* tb_top.sv */
// Testbench: drives the decoder through its register port
`timescale 1ns/1ps
module tb_top;
  localparam int IDX = 40;
  localparam int CPM = 10;
  localparam int ST6 = fcfd_pkg::STEP_6_MS * CPM;
  localparam int ST12 = fcfd_pkg::STEP_12_MS * CPM;
  localparam int ST20 = fcfd_pkg::STEP_20_MS * CPM;
  localparam int ST30 = fcfd_pkg::STEP_30_MS * CPM;
  localparam int ST2 = fcfd_pkg::STEP_2_MS * CPM;
  localparam int ST3 = fcfd_pkg::STEP_3_MS * CPM;
  localparam int SET_STD = 40;
  localparam int SET_FAST = 20;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ready_req = 1'b1;
  logic [7:0] rdata;
  logic drive_ready, index_pulse, cmd_done, cmd_start, cmd_abort, spindle_motor_on, irq;
  logic [23:0] step_period_cyc;
  fcfd_pkg::fcfd_opts_t opts;
  logic [23:0] per_tab [8] = '{24'(ST6), 24'(ST12), 24'(ST20), 24'(ST30), 24'(ST6), 24'(ST12), 24'(ST2), 24'(ST3)};
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n_start = 0;
  int n_done = 0;
  int start_cyc = 0;
  int lat;
  int k;

  always #2 clock = ~clock;

  fcfd_decoder #(.STEP_6_CYC(ST6), .STEP_12_CYC(ST12), .STEP_20_CYC(ST20), .STEP_30_CYC(ST30), .STEP_2_CYC(ST2),
    .STEP_3_CYC(ST3), .SETTLE_STD_CYC(SET_STD), .SETTLE_FAST_CYC(SET_FAST)) dut_u (
    .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .drive_ready(drive_ready), .index_pulse(index_pulse), .cmd_done(cmd_done), .step_period_cyc(step_period_cyc),
    .opts(opts), .cmd_start(cmd_start), .cmd_abort(cmd_abort), .spindle_motor_on(spindle_motor_on), .irq(irq));

  fcfd_drive_model #(.IDX_PER(IDX)) drv_u (
    .clock(clock), .nrst(nrst), .ready_req(ready_req), .cmd_start(cmd_start),
    .drive_ready(drive_ready), .index_pulse(index_pulse), .cmd_done(cmd_done));

  // Cycle stamp and pulse counters
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cmd_start === 1'b1) begin
      n_start <= n_start + 1;
      start_cyc <= cyc;
    end
    if (cmd_done === 1'b1) begin
      n_done <= n_done + 1;
    end
  end

  task automatic finish_test();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk({16'h0, rdata}, {16'h0, exp});
    @(posedge clock);
  endtask

  task automatic wait_cnt(ref int c, input int old, input int lim);
    int i;
    i = 0;
    while (c == old && i < lim) begin
      @(posedge clock);
      i++;
    end
    if (c == old) begin
      n_errors++;
      finish_test();
    end
  endtask

  // Issue a command, wait for go and completion, clear the status
  task automatic run_cmd(input logic [7:0] c, output int l);
    int s;
    int d;
    int t;
    s = n_start;
    d = n_done;
    t = cyc;
    wr_reg(fcfd_pkg::ADDR_CMD, c);
    wait_cnt(n_start, s, 3000);
    l = start_cyc - t;
    wait_cnt(n_done, d, 50);
    wr_reg(fcfd_pkg::ADDR_IRQ_STAT, 8'hFF);
  endtask

  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd_chk(fcfd_pkg::ADDR_IRQ_MASK, fcfd_pkg::IRQ_MASK_RST);
    rd_chk(fcfd_pkg::ADDR_VARIANT, fcfd_pkg::VARIANT_RST);
    wr_reg(4'hF, 8'h5A);
    rd_chk(4'hF, 8'h00);
    wr_reg(fcfd_pkg::ADDR_IRQ_MASK, 8'hFF);
    // Step rate table on both timing variants, spin-up disabled
    for (int v = 0; v < 2; v++) begin
      wr_reg(fcfd_pkg::ADDR_VARIANT, 8'(v));
      for (int r = 0; r < 4; r++) begin
        run_cmd(8'h18 | 8'(r), lat);
        chk(step_period_cyc, per_tab[v * 4 + r]);
        chk(24'(opts), {13'h0, 2'(r), 9'h100});
      end
    end
    // Sector and step option fields, settle timing
    run_cmd(8'hAE, lat);
    chk(24'(opts), 24'h004);
    chk(24'(lat >= SET_FAST && lat < SET_STD), 24'h1);
    wr_reg(fcfd_pkg::ADDR_VARIANT, 8'h00);
    run_cmd(8'hBD, lat);
    chk(24'(opts), 24'h047);
    chk(24'(lat >= SET_STD), 24'h1);
    run_cmd(8'h1C, lat);
    chk(24'(opts), 24'h180);
    chk(24'(lat < 4), 24'h1);
    wr_reg(fcfd_pkg::ADDR_VARIANT, 8'h02);
    run_cmd(8'hAB, lat);
    chk(24'(opts), 24'h019);
    rd_chk(fcfd_pkg::ADDR_OPT, 8'h1C);
    run_cmd(8'hF4, lat);
    chk(24'(opts), 24'h004);
    // Spin-up with motor off, then immediate start with motor on
    wr_reg(fcfd_pkg::ADDR_VARIANT, 8'h00);
    run_cmd(8'h80, lat);
    chk(24'(opts), 24'h020);
    chk(24'(lat >= 5 * IDX && spindle_motor_on === 1'b1), 24'h1);
    run_cmd(8'h80, lat);
    chk(24'(lat < 4), 24'h1);
    // Track commands on a motor variant: precompensation on write only, settle on bit 2
    run_cmd(8'hF0, lat);
    chk(24'(opts), 24'h022);
    run_cmd(8'hC4, lat);
    chk(24'(opts), 24'h024);
    chk(24'(lat >= SET_STD), 24'h1);
    // Abort during settle: no start, no interrupt
    wr_reg(fcfd_pkg::ADDR_VARIANT, 8'h02);
    k = n_start;
    wr_reg(fcfd_pkg::ADDR_CMD, 8'h84);
    wr_reg(fcfd_pkg::ADDR_CMD, 8'hD0);
    repeat (60) @(posedge clock);
    chk(24'(n_start - k), 24'h0);
    rd_chk(fcfd_pkg::ADDR_IRQ_STAT, 8'h00);
    rd_chk(fcfd_pkg::ADDR_CMD, 8'hD0);
    // Immediate interrupt, masking and clearing
    wr_reg(fcfd_pkg::ADDR_CMD, 8'hD8);
    rd_chk(fcfd_pkg::ADDR_IRQ_STAT, 8'h08);
    chk(24'(irq), 24'h1);
    wr_reg(fcfd_pkg::ADDR_IRQ_MASK, 8'h00);
    @(posedge clock);
    chk(24'(irq), 24'h0);
    wr_reg(fcfd_pkg::ADDR_IRQ_MASK, 8'hFF);
    wr_reg(fcfd_pkg::ADDR_IRQ_STAT, 8'h08);
    rd_chk(fcfd_pkg::ADDR_IRQ_STAT, 8'h00);
    chk(24'(irq), 24'h0);
    // Index interrupt on every pulse until terminated
    wr_reg(fcfd_pkg::ADDR_CMD, 8'hD4);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        wr_reg(fcfd_pkg::ADDR_CMD, 8'hD0);
      end
      wr_reg(fcfd_pkg::ADDR_IRQ_STAT, 8'hFF);
      repeat (IDX + 10) @(posedge clock);
      rd_chk(fcfd_pkg::ADDR_IRQ_STAT, (i < 2) ? 8'h04 : 8'h00);
    end
    // Ready transitions: reported on side-compare variant only
    for (int v = 2; v >= 0; v -= 2) begin
      wr_reg(fcfd_pkg::ADDR_VARIANT, 8'(v));
      wr_reg(fcfd_pkg::ADDR_CMD, 8'hD3);
      wr_reg(fcfd_pkg::ADDR_IRQ_STAT, 8'hFF);
      ready_req <= 1'b0;
      repeat (10) @(posedge clock);
      rd_chk(fcfd_pkg::ADDR_IRQ_STAT, (v != 0) ? 8'h02 : 8'h00);
      ready_req <= 1'b1;
      repeat (10) @(posedge clock);
      rd_chk(fcfd_pkg::ADDR_IRQ_STAT, (v != 0) ? 8'h03 : 8'h00);
      wr_reg(fcfd_pkg::ADDR_CMD, 8'hD0);
      wr_reg(fcfd_pkg::ADDR_IRQ_STAT, 8'hFF);
    end
    finish_test();
  end
endmodule
